//--- dv/tses_core_tb_top.sv
// Self-checking testbench of the execution unit
`timescale 1ns/10ps
module tses_core_tb_top;
	logic clk, rst_b, cmd_valid, use_imm, dbg_wr, mem_ack, slow, cmd_ready, done, fault, mem_req, mem_we;
	logic [3:0] op, dbg_addr, flags, mem_be, fl_e;
	logic [2:0] rd, rn, rm, sd, sn, sm;
	logic [31:0] imm, dbg_wdata, mem_rdata, pc, mem_addr, mem_wdata, dbg_rdata, pc_e, a, b, r, v;
	logic [8:0] reglist;
	logic [32:0] s;
	logic [31:0] sh [0:15];
	logic [68:0] exp_mem [$];
	logic [36:0] exp_done [$];
	logic [68:0] em;
	logic [36:0] ed;
	logic flt_e;
	int error_cnt, samples_checked;
	tses_pkg::tses_op_t ops [0:4];
	tses_pkg::tses_op_t bops [0:3];
	tses_core u_dut (.clk_i(clk), .rst_b_i(rst_b), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .op_i(op),
		.rd_i(rd), .rn_i(rn), .rm_i(rm), .use_imm_i(use_imm), .imm_i(imm), .reglist_i(reglist), .done_o(done),
		.fault_o(fault), .pc_o(pc), .flags_o(flags), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
		.mem_wdata_o(mem_wdata), .mem_be_o(mem_be), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
		.dbg_wr_i(dbg_wr), .dbg_addr_i(dbg_addr), .dbg_wdata_i(dbg_wdata), .dbg_rdata_o(dbg_rdata));
	tses_mem_model u_mem (.clk_i(clk), .rst_b_i(rst_b), .slow_i(slow), .req_i(mem_req), .we_i(mem_we),
		.addr_i(mem_addr), .wdata_i(mem_wdata), .be_i(mem_be), .ack_o(mem_ack), .rdata_o(mem_rdata));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic stop_test();
		$display("Counts: %0d mismatches in %0d comparisons", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Scoreboard takes the oldest note whenever a result shows
	always @(posedge clk)
	begin
		if (mem_req && mem_ack)
		begin
			em = exp_mem.size() > 0 ? exp_mem.pop_front() : 69'h0;
			chk("mem_addr", em[63:32], mem_addr);
			chk("mem_we", {31'h0, em[68]}, {31'h0, mem_we});
			if (em[68])
			begin
				chk("mem_wdata", em[31:0], mem_wdata);
				chk("mem_be", {28'h0, em[67:64]}, {28'h0, mem_be});
			end
		end
		if (done)
		begin
			ed = exp_done.size() > 0 ? exp_done.pop_front() : 37'h0;
			chk("pc", ed[31:0], pc);
			chk("flags", {28'h0, ed[35:32]}, {28'h0, flags});
			chk("fault", {31'h0, ed[36]}, {31'h0, fault});
			chk("ready", 32'h1, {31'h0, cmd_ready});
		end
	end
	task automatic wr_reg(input logic [3:0] idx, input logic [31:0] val);
		@(posedge clk);
		dbg_wr <= 1'b1;
		dbg_addr <= idx;
		dbg_wdata <= val;
		@(posedge clk);
		dbg_wr <= 1'b0;
		sh[idx] = val;
	endtask : wr_reg
	task automatic rd_chk(input string name, input logic [3:0] idx);
		@(posedge clk);
		dbg_addr <= idx;
		repeat (2) @(posedge clk);
		#1;
		chk(name, sh[idx], dbg_rdata);
	endtask : rd_chk
	task automatic issue(input logic [3:0] o, input logic [2:0] d, n, m, input logic ui, input logic [31:0] im,
		input logic [8:0] rl);
		int k;
		exp_done.push_back({flt_e, fl_e, pc_e});
		@(posedge clk);
		cmd_valid <= 1'b1;
		op <= o;
		rd <= d;
		rn <= n;
		rm <= m;
		use_imm <= ui;
		imm <= im;
		reglist <= rl;
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
		chk("ready_busy", 32'h0, {31'h0, cmd_ready});
		for (k = 0; k < 300 && done !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		if (k == 300)
		begin
			chk("done_wait", 32'h0, 32'h1);
			stop_test();
		end
	endtask : issue
	task automatic store(input logic [3:0] o, input logic [2:0] d, input logic ui, input logic [31:0] im, ad, dt,
		input logic [3:0] be);
		exp_mem.push_back({1'b1, be, ad, dt});
		pc_e = pc_e + 32'h2;
		issue(o, d, 3'h6, 3'h7, ui, im, 9'h000);
	endtask : store
	initial
	begin
		{rst_b, cmd_valid, use_imm, dbg_wr, slow, op, dbg_addr, rd, rn, rm, imm, dbg_wdata, reglist} = '0;
		error_cnt = 0;
		samples_checked = 0;
		ops = '{tses_pkg::OP_AND_TEST, tses_pkg::OP_HALFWORD_ZERO_EXTEND, tses_pkg::OP_ROTATE_RIGHT_FLAGS,
			tses_pkg::OP_REVERSE_SUBTRACT_FLAGS, tses_pkg::OP_SUBTRACT_CARRY_FLAGS};
		bops = '{tses_pkg::OP_INDIRECT_BRANCH, tses_pkg::OP_INDIRECT_BRANCH, tses_pkg::OP_INDIRECT_BRANCH_LINK,
			tses_pkg::OP_BRANCH_LINK};
		for (int i = 0; i < 16; i++)
			sh[i] = 32'h0;
		pc_e = 32'h0;
		fl_e = 4'h0;
		flt_e = 1'b0;
		void'($urandom(32'ha9054d68));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		chk("pc_reset", 32'h0, pc);
		chk("flags_reset", 32'h0, {28'h0, flags});
		chk("ctl_reset", 32'h8, {28'h0, cmd_ready, done, fault, mem_req});
		$display("test reset done");
		for (int i = 0; i < 25; i++)
		begin
			sn = 3'($urandom_range(7));
			sm = 3'($urandom_range(7));
			sd = 3'($urandom_range(7));
			if (i % 5 == 1)
				sn = sm;
			wr_reg({1'b0, sn}, i < 5 ? 32'h0 : $urandom);
			wr_reg({1'b0, sm}, (i >= 10 && i < 15) ? ($urandom & 32'hffff_ff00) : $urandom);
			a = sh[sn];
			b = sh[sm];
			case (i % 5)
				0: begin r = a & b; fl_e[3:2] = {r[31], r == 32'h0}; end
				1: sh[sd] = {16'h0000, b[15:0]};
				2: begin r = 32'({a, a} >> b[4:0]); sh[sd] = r; fl_e[3:2] = {r[31], r == 32'h0};
					if (b[7:0] != 8'h0) fl_e[1] = r[31]; end
				3: begin r = 32'h0 - a; sh[sd] = r; fl_e = {r[31], r == 32'h0, a == 32'h0, a == 32'h8000_0000}; end
				default: begin s = {1'b0, a} + {1'b0, ~b} + {32'h0, fl_e[1]}; r = s[31:0]; sh[sd] = r;
					fl_e = {r[31], r == 32'h0, s[32], (a[31] != b[31]) && (r[31] != a[31])}; end
			endcase
			pc_e = pc_e + 32'h2;
			issue(ops[i % 5], sd, sn, sm, 1'b0, 32'h0, 9'h000);
			rd_chk("alu_dest", {1'b0, sd});
		end
		$display("test alu_flags done");
		wr_reg(4'h6, 32'h40);
		wr_reg(4'h7, 32'h8);
		store(tses_pkg::OP_WORD_STORE, 3'h0, 1'b1, 32'h4, 32'h44, sh[0], 4'hf);
		store(tses_pkg::OP_WORD_STORE, 3'h1, 1'b0, 32'h0, 32'h48, sh[1], 4'hf);
		store(tses_pkg::OP_HALFWORD_STORE, 3'h2, 1'b1, 32'h2, 32'h42, {2{sh[2][15:0]}}, 4'hc);
		store(tses_pkg::OP_HALFWORD_STORE, 3'h2, 1'b0, 32'h0, 32'h48, {2{sh[2][15:0]}}, 4'h3);
		for (int k = 0; k < 4; k++)
			store(tses_pkg::OP_BYTE_STORE, 3'h3, 1'b1, 32'(k), 32'h40 + 32'(k), {4{sh[3][7:0]}}, 4'h1 << k);
		$display("test stores done");
		slow = 1'b1;
		wr_reg(4'hd, 32'h80);
		wr_reg(4'he, $urandom | 32'h1);
		exp_mem.push_back({5'h1f, 32'h40, sh[1]});
		exp_mem.push_back({5'h1f, 32'h44, sh[3]});
		exp_mem.push_back({5'h1f, 32'h48, sh[5]});
		sh[6] = 32'h4c;
		pc_e = pc_e + 32'h2;
		issue(tses_pkg::OP_MULTI_STORE, 3'h0, 3'h6, 3'h0, 1'b0, 32'h0, 9'h02a);
		rd_chk("multi_base", 4'h6);
		exp_mem.push_back({5'h1f, 32'h74, sh[0]});
		exp_mem.push_back({5'h1f, 32'h78, sh[2]});
		exp_mem.push_back({5'h1f, 32'h7c, sh[14]});
		sh[13] = 32'h74;
		pc_e = pc_e + 32'h2;
		issue(tses_pkg::OP_PUSH, 3'h0, 3'h0, 3'h0, 1'b0, 32'h0, 9'h105);
		rd_chk("push_sp", 4'hd);
		for (int k = 0; k < 3; k++)
			exp_mem.push_back({5'h00, 32'h74 + 32'(4 * k), 32'h0});
		sh[4] = sh[0];
		sh[5] = sh[2];
		sh[13] = 32'h80;
		pc_e = sh[14] & 32'hffff_fffe;
		issue(tses_pkg::OP_POP, 3'h0, 3'h0, 3'h0, 1'b0, 32'h0, 9'h130);
		slow = 1'b0;
		rd_chk("pop_r4", 4'h4);
		rd_chk("pop_r5", 4'h5);
		rd_chk("pop_sp", 4'hd);
		pc_e = pc_e + 32'h2;
		issue(tses_pkg::OP_POP, 3'h0, 3'h0, 3'h0, 1'b0, 32'h0, 9'h000);
		rd_chk("pop_empty_sp", 4'hd);
		$display("test stack done");
		for (int k = 0; k < 4; k++)
		begin
			v = $urandom;
			v[0] = (k != 1);
			wr_reg(4'h5, v);
			flt_e = !v[0];
			if (k > 1)
				sh[14] = (pc_e + (k == 3 ? 32'h4 : 32'h2)) | 32'h1;
			pc_e = k == 3 ? pc_e + 32'h104 : v & 32'hffff_fffe;
			issue(bops[k], 3'h0, 3'h0, 3'h5, 1'b0, 32'h100, 9'h000);
			rd_chk("link", 4'he);
		end
		pc_e = pc_e + 32'h2;
		issue(tses_pkg::OP_NOP, 3'h0, 3'h0, 3'h0, 1'b0, 32'h0, 9'h000);
		sh[15] = pc_e;
		rd_chk("pc_read", 4'hf);
		$display("test branches done");
		chk("mem_left", 32'h0, 32'(exp_mem.size()));
		chk("done_left", 32'h0, 32'(exp_done.size()));
		stop_test();
	end
endmodule : tses_core_tb_top

//--- dv/tses_mem_model.sv
// Data memory model on the far side of the execution unit
`timescale 1ns/10ps
module tses_mem_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic slow_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] be_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [0:63];
	logic [1:0] wait_cnt;
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			ack_o <= 1'b0;
			wait_cnt <= 2'h0;
			rdata_o <= 32'h5a5a_a5a5;
		end
		else if (req_i && !ack_o && (!slow_i || wait_cnt == 2'h3))
		begin
			ack_o <= 1'b1;
			wait_cnt <= 2'h0;
			rdata_o <= mem[addr_i[7:2]];
			for (int i = 0; i < 4; i++)
			begin
				if (we_i && be_i[i])
				begin
					mem[addr_i[7:2]][8*i+:8] <= wdata_i[8*i+:8];
				end
			end
		end
		else
		begin
			ack_o <= 1'b0;
			wait_cnt <= req_i ? wait_cnt + 2'h1 : 2'h0;
			// Released data lines keep changing
			rdata_o <= ~rdata_o;
		end
	end
endmodule : tses_mem_model

//--- hw/tses_core.sv
// Execution unit for the stack, store, test, extend, branch and flag instructions
`timescale 1ns/10ps
module tses_core (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [3:0] op_i,
	input wire logic [2:0] rd_i,
	input wire logic [2:0] rn_i,
	input wire logic [2:0] rm_i,
	input wire logic use_imm_i,
	input wire logic [31:0] imm_i,
	input wire logic [8:0] reglist_i,
	output logic done_o,
	output logic fault_o,
	output logic [31:0] pc_o,
	output logic [3:0] flags_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	output logic [3:0] mem_be_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	input wire logic dbg_wr_i,
	input wire logic [3:0] dbg_addr_i,
	input wire logic [31:0] dbg_wdata_i,
	output logic [31:0] dbg_rdata_o
);
	tses_pkg::tses_state_t state;
	tses_pkg::tses_op_t op_q;
	logic [3:0] rd_q;
	logic [3:0] rn_q;
	logic [3:0] rm_q;
	logic use_imm_q;
	logic [31:0] imm_q;
	logic [8:0] list_q;
	logic [31:0] addr_q;
	logic [31:0] base_new;
	logic multi_q;
	logic pc_loaded;
	logic rf_we;
	logic [3:0] rf_waddr;
	logic [31:0] rf_wdata;
	logic [3:0] ra_addr;
	logic [31:0] rf_a;
	logic [31:0] rf_b;
	logic [31:0] rf_c;
	logic [3:0] cur_idx;
	logic [3:0] cur_reg;
	logic [31:0] alu_res;
	logic [3:0] next_flags;
	logic [31:0] and_val;
	logic [32:0] sum;
	logic [31:0] rot_val;
	logic [4:0] rot_n;
	logic [31:0] st_addr;
	logic [31:0] link_val;
	logic [3:0] xfer_cnt;

	tses_regfile u_regfile (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.we_i(rf_we),
		.waddr_i(rf_waddr),
		.wdata_i(rf_wdata),
		.raddr_a_i(ra_addr),
		.rdata_a_o(rf_a),
		.raddr_b_i(rm_q),
		.rdata_b_o(rf_b),
		.raddr_c_i(dbg_addr_i),
		.rdata_c_o(rf_c)
	);

	assign cur_idx = tses_pkg::lowest_idx(list_q);
	assign cur_reg = (cur_idx == tses_pkg::LIST_TOP_IDX) ? tses_pkg::LR_IDX : cur_idx;
	assign ra_addr = (state == tses_pkg::ST_XFER) ? (multi_q ? cur_reg : rd_q) : rn_q;
	assign and_val = rf_a & rf_b;
	assign rot_n = rf_b[4:0];
	assign rot_val = (rf_a >> rot_n) | (rf_a << (6'd32 - {1'b0, rot_n}));
	assign st_addr = rf_a + (use_imm_q ? imm_q : rf_b);

	// Result and flag computation for the one-cycle operations
	always_comb
	begin
		alu_res = rf_a;
		next_flags = flags_o;
		sum = 33'h0_0000_0000;
		link_val = pc_o + tses_pkg::SHORT_INSN_BYTES;
		unique case (op_q)
			tses_pkg::OP_AND_TEST:
			begin
				next_flags[tses_pkg::FLAG_N] = and_val[31];
				next_flags[tses_pkg::FLAG_Z] = (and_val == 32'h0000_0000);
			end
			tses_pkg::OP_HALFWORD_ZERO_EXTEND:
			begin
				alu_res = {16'h0000, rf_b[15:0]};
			end
			tses_pkg::OP_ROTATE_RIGHT_FLAGS:
			begin
				alu_res = (rot_n == 5'h00) ? rf_a : rot_val;
				next_flags[tses_pkg::FLAG_N] = alu_res[31];
				next_flags[tses_pkg::FLAG_Z] = (alu_res == 32'h0000_0000);
				if (rf_b[7:0] != 8'h00)
				begin
					next_flags[tses_pkg::FLAG_C] = alu_res[31];
				end
			end
			tses_pkg::OP_REVERSE_SUBTRACT_FLAGS:
			begin
				sum = tses_pkg::add_carry(32'h0000_0000, ~rf_a, 1'b1);
				alu_res = sum[31:0];
				next_flags = {sum[31], sum[31:0] == 32'h0000_0000, sum[32],
					tses_pkg::add_ovf(32'h0000_0000, ~rf_a, sum[31:0])};
			end
			tses_pkg::OP_SUBTRACT_CARRY_FLAGS:
			begin
				sum = tses_pkg::add_carry(rf_a, ~rf_b, flags_o[tses_pkg::FLAG_C]);
				alu_res = sum[31:0];
				next_flags = {sum[31], sum[31:0] == 32'h0000_0000, sum[32],
					tses_pkg::add_ovf(rf_a, ~rf_b, sum[31:0])};
			end
			tses_pkg::OP_BRANCH_LINK:
			begin
				link_val = pc_o + tses_pkg::LONG_INSN_BYTES;
			end
			default:
			begin
				alu_res = rf_a;
			end
		endcase
	end

	// Register write port selection
	always_comb
	begin
		rf_we = 1'b0;
		rf_waddr = rd_q;
		rf_wdata = alu_res;
		unique case (state)
			tses_pkg::ST_IDLE:
			begin
				rf_we = dbg_wr_i && !cmd_valid_i && (dbg_addr_i != 4'hf);
				rf_waddr = dbg_addr_i;
				rf_wdata = dbg_wdata_i;
			end
			tses_pkg::ST_EXEC:
			begin
				if (op_q == tses_pkg::OP_HALFWORD_ZERO_EXTEND || op_q == tses_pkg::OP_ROTATE_RIGHT_FLAGS ||
					op_q == tses_pkg::OP_REVERSE_SUBTRACT_FLAGS || op_q == tses_pkg::OP_SUBTRACT_CARRY_FLAGS)
				begin
					rf_we = 1'b1;
				end
				else if (op_q == tses_pkg::OP_INDIRECT_BRANCH_LINK || op_q == tses_pkg::OP_BRANCH_LINK)
				begin
					rf_we = 1'b1;
					rf_waddr = tses_pkg::LR_IDX;
					rf_wdata = link_val | 32'h0000_0001;
				end
			end
			tses_pkg::ST_XFER:
			begin
				rf_we = mem_req_o && mem_ack_i && !mem_we_o && (cur_idx != tses_pkg::LIST_TOP_IDX);
				rf_waddr = cur_idx;
				rf_wdata = mem_rdata_i;
			end
			tses_pkg::ST_FIN:
			begin
				rf_we = multi_q;
				rf_waddr = rn_q;
				rf_wdata = (op_q == tses_pkg::OP_PUSH) ? base_new : addr_q;
			end
		endcase
	end

	// Sequencing
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			state <= tses_pkg::ST_IDLE;
			cmd_ready_o <= 1'b1;
			done_o <= 1'b0;
			op_q <= tses_pkg::OP_NOP;
			rd_q <= 4'h0;
			rn_q <= 4'h0;
			rm_q <= 4'h0;
			use_imm_q <= 1'b0;
			imm_q <= 32'h0000_0000;
			list_q <= 9'h000;
			multi_q <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			unique case (state)
				tses_pkg::ST_IDLE:
				begin
					if (cmd_valid_i)
					begin
						state <= tses_pkg::ST_EXEC;
						cmd_ready_o <= 1'b0;
						op_q <= tses_pkg::tses_op_t'(op_i);
						rd_q <= {1'b0, rd_i};
						rn_q <= (op_i == tses_pkg::OP_PUSH || op_i == tses_pkg::OP_POP) ? tses_pkg::SP_IDX : {1'b0, rn_i};
						rm_q <= {1'b0, rm_i};
						use_imm_q <= use_imm_i;
						imm_q <= imm_i;
						list_q <= (op_i == tses_pkg::OP_MULTI_STORE) ? {1'b0, reglist_i[7:0]} : reglist_i;
						multi_q <= (op_i == tses_pkg::OP_MULTI_STORE || op_i == tses_pkg::OP_PUSH || op_i == tses_pkg::OP_POP);
					end
				end
				tses_pkg::ST_EXEC:
				begin
					if (multi_q || op_q == tses_pkg::OP_HALFWORD_STORE || op_q == tses_pkg::OP_WORD_STORE ||
						op_q == tses_pkg::OP_BYTE_STORE)
					begin
						state <= (multi_q && list_q == 9'h000) ? tses_pkg::ST_FIN : tses_pkg::ST_XFER;
					end
					else
					begin
						state <= tses_pkg::ST_IDLE;
						cmd_ready_o <= 1'b1;
						done_o <= 1'b1;
					end
				end
				tses_pkg::ST_XFER:
				begin
					if (mem_req_o && mem_ack_i)
					begin
						list_q[cur_idx] <= 1'b0;
						if (!multi_q || (list_q & (list_q - 9'h001)) == 9'h000)
						begin
							state <= tses_pkg::ST_FIN;
						end
					end
				end
				tses_pkg::ST_FIN:
				begin
					state <= tses_pkg::ST_IDLE;
					cmd_ready_o <= 1'b1;
					done_o <= 1'b1;
				end
			endcase
		end
	end

	// Memory port and transfer address
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 32'h0000_0000;
			mem_wdata_o <= 32'h0000_0000;
			mem_be_o <= 4'h0;
			addr_q <= 32'h0000_0000;
			base_new <= 32'h0000_0000;
		end
		else if (state == tses_pkg::ST_EXEC)
		begin
			unique case (op_q)
				tses_pkg::OP_PUSH:
				begin
					addr_q <= rf_a - tses_pkg::list_bytes(list_q);
					base_new <= rf_a - tses_pkg::list_bytes(list_q);
				end
				tses_pkg::OP_MULTI_STORE, tses_pkg::OP_POP:
				begin
					addr_q <= rf_a;
				end
				default:
				begin
					addr_q <= st_addr;
				end
			endcase
		end
		else if (state == tses_pkg::ST_XFER)
		begin
			if (!mem_req_o)
			begin
				mem_req_o <= 1'b1;
				mem_we_o <= (op_q != tses_pkg::OP_POP);
				mem_addr_o <= addr_q;
				unique case (op_q)
					tses_pkg::OP_HALFWORD_STORE:
					begin
						mem_wdata_o <= {2{rf_a[15:0]}};
						mem_be_o <= addr_q[1] ? tses_pkg::BE_HALF_HI : tses_pkg::BE_HALF_LO;
					end
					tses_pkg::OP_BYTE_STORE:
					begin
						mem_wdata_o <= {4{rf_a[7:0]}};
						mem_be_o <= tses_pkg::BE_BYTE0 << addr_q[1:0];
					end
					default:
					begin
						mem_wdata_o <= rf_a;
						mem_be_o <= tses_pkg::BE_WORD;
					end
				endcase
			end
			else if (mem_ack_i)
			begin
				mem_req_o <= 1'b0;
				addr_q <= addr_q + tses_pkg::WORD_BYTES;
			end
		end
	end

	// Program counter, flags and fault
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			pc_o <= tses_pkg::PC_RESET;
			flags_o <= tses_pkg::FLAGS_RESET;
			fault_o <= 1'b0;
			pc_loaded <= 1'b0;
		end
		else
		begin
			if (state == tses_pkg::ST_IDLE && cmd_valid_i)
			begin
				fault_o <= 1'b0;
				pc_loaded <= 1'b0;
			end
			if (state == tses_pkg::ST_EXEC)
			begin
				flags_o <= next_flags;
				if (op_q == tses_pkg::OP_INDIRECT_BRANCH || op_q == tses_pkg::OP_INDIRECT_BRANCH_LINK)
				begin
					pc_o <= rf_b & ~32'h0000_0001;
					fault_o <= !rf_b[tses_pkg::ISA_BIT];
				end
				else if (op_q == tses_pkg::OP_BRANCH_LINK)
				begin
					pc_o <= pc_o + tses_pkg::LONG_INSN_BYTES + imm_q;
				end
				else if (!(multi_q || op_q == tses_pkg::OP_HALFWORD_STORE || op_q == tses_pkg::OP_WORD_STORE ||
					op_q == tses_pkg::OP_BYTE_STORE))
				begin
					pc_o <= pc_o + tses_pkg::SHORT_INSN_BYTES;
				end
			end
			if (state == tses_pkg::ST_XFER && mem_req_o && mem_ack_i && !mem_we_o &&
				cur_idx == tses_pkg::LIST_TOP_IDX)
			begin
				pc_o <= mem_rdata_i & ~32'h0000_0001;
				fault_o <= !mem_rdata_i[tses_pkg::ISA_BIT];
				pc_loaded <= 1'b1;
			end
			if (state == tses_pkg::ST_FIN && !pc_loaded)
			begin
				pc_o <= pc_o + tses_pkg::SHORT_INSN_BYTES;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			dbg_rdata_o <= 32'h0000_0000;
		end
		else
		begin
			dbg_rdata_o <= (dbg_addr_i == 4'hf) ? pc_o : rf_c;
		end
	end

	// Words moved by the current command, counted apart from the address logic
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			xfer_cnt <= 4'h0;
		end
		else if (state == tses_pkg::ST_IDLE && cmd_valid_i)
		begin
			xfer_cnt <= 4'h0;
		end
		else if (mem_req_o && mem_ack_i)
		begin
			xfer_cnt <= xfer_cnt + 4'h1;
		end
	end

	AST_MULTI_STEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_XFER && multi_q && mem_req_o && mem_ack_i && (list_q & (list_q - 9'h001)) != 9'h000)
		|-> ##2 (mem_req_o && mem_addr_o == $past(mem_addr_o, 2) + tses_pkg::WORD_BYTES))
		else $error("multi transfer address did not step by one word");
	AST_PUSH_SP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_FIN && op_q == tses_pkg::OP_PUSH)
		|-> (rf_we && rf_waddr == tses_pkg::SP_IDX && rf_wdata == rf_a - {26'h0, xfer_cnt, 2'b00}))
		else $error("push stack pointer write back wrong");
	AST_POP_SP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_FIN && op_q == tses_pkg::OP_POP)
		|-> ((rf_we && rf_waddr == tses_pkg::SP_IDX && rf_wdata == rf_a + {26'h0, xfer_cnt, 2'b00}) ##1 done_o))
		else $error("pop did not adjust stack pointer");
	AST_TEST_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_EXEC && op_q == tses_pkg::OP_AND_TEST) |=>
		(flags_o[1:0] == $past(flags_o[1:0]) && flags_o[tses_pkg::FLAG_Z] == ($past(and_val) == 32'h0000_0000)))
		else $error("and-test flags wrong");
	AST_ZEXT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_EXEC && op_q == tses_pkg::OP_HALFWORD_ZERO_EXTEND) |->
		(rf_we && rf_wdata == {16'h0000, rf_b[15:0]}) ##1 $stable(flags_o))
		else $error("zero extend result or flags wrong");
	AST_HALF_BE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(mem_req_o && op_q == tses_pkg::OP_HALFWORD_STORE) |->
		(mem_we_o && (mem_be_o == tses_pkg::BE_HALF_LO || mem_be_o == tses_pkg::BE_HALF_HI) &&
		mem_wdata_o[15:0] == mem_wdata_o[31:16]))
		else $error("halfword store lanes wrong");
	AST_WORD_STORE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(mem_req_o) && op_q == tses_pkg::OP_WORD_STORE |-> (mem_be_o == tses_pkg::BE_WORD && $stable(flags_o)))
		else $error("word store lanes or flags wrong");
	AST_PC_SELECT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_EXEC && op_q == tses_pkg::OP_INDIRECT_BRANCH) |=>
		(pc_o[0] == 1'b0 && fault_o == !$past(rf_b[0])))
		else $error("branch target select bit handled wrong");
	AST_LINK_ODD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_EXEC && rf_we && rf_waddr == tses_pkg::LR_IDX) |-> rf_wdata[0])
		else $error("link value bit 0 not set");
	AST_FLAG_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == tses_pkg::ST_EXEC && op_q == tses_pkg::OP_ROTATE_RIGHT_FLAGS) |=>
		(flags_o[tses_pkg::FLAG_V] == $past(flags_o[tses_pkg::FLAG_V])))
		else $error("rotate changed overflow flag");
endmodule : tses_core

//--- hw/tses_pkg.sv
// Constants, types and helper functions for the instruction subset execution unit
package tses_pkg;
	localparam int XLEN = 32;
	localparam logic [3:0] SP_IDX = 4'hd;
	localparam logic [3:0] LR_IDX = 4'he;
	localparam logic [3:0] LIST_TOP_IDX = 4'h8;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 0;
	localparam int ISA_BIT = 0;
	localparam int LIST_W = 9;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam logic [31:0] SP_RESET = 32'h0000_0000;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] SHORT_INSN_BYTES = 32'h0000_0002;
	localparam logic [31:0] LONG_INSN_BYTES = 32'h0000_0004;
	localparam logic [3:0] BE_WORD = 4'hf;
	localparam logic [3:0] BE_HALF_LO = 4'h3;
	localparam logic [3:0] BE_HALF_HI = 4'hc;
	localparam logic [3:0] BE_BYTE0 = 4'h1;

	typedef enum logic [3:0] {
		OP_MULTI_STORE = 4'h0,
		OP_PUSH = 4'h1,
		OP_POP = 4'h2,
		OP_AND_TEST = 4'h3,
		OP_HALFWORD_ZERO_EXTEND = 4'h4,
		OP_HALFWORD_STORE = 4'h5,
		OP_WORD_STORE = 4'h6,
		OP_BYTE_STORE = 4'h7,
		OP_INDIRECT_BRANCH = 4'h8,
		OP_INDIRECT_BRANCH_LINK = 4'h9,
		OP_BRANCH_LINK = 4'ha,
		OP_ROTATE_RIGHT_FLAGS = 4'hb,
		OP_REVERSE_SUBTRACT_FLAGS = 4'hc,
		OP_SUBTRACT_CARRY_FLAGS = 4'hd,
		OP_NOP = 4'he
	} tses_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_XFER = 2'b10,
		ST_FIN = 2'b11
	} tses_state_t;

	function automatic logic [32:0] add_carry(input logic [31:0] a, input logic [31:0] b, input logic cin);
		add_carry = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
	endfunction : add_carry

	function automatic logic add_ovf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
		add_ovf = (a[31] == b[31]) && (s[31] != a[31]);
	endfunction : add_ovf

	function automatic logic [31:0] list_bytes(input logic [LIST_W-1:0] list);
		logic [31:0] n;
		n = 32'h0000_0000;
		for (int i = 0; i < LIST_W; i++)
		begin
			n = n + {31'h0000_0000, list[i]};
		end
		list_bytes = n << 2;
	endfunction : list_bytes

	function automatic logic [3:0] lowest_idx(input logic [LIST_W-1:0] list);
		logic [3:0] r;
		r = 4'h0;
		for (int i = LIST_W - 1; i >= 0; i--)
		begin
			if (list[i])
			begin
				r = 4'(i);
			end
		end
		lowest_idx = r;
	endfunction : lowest_idx
endpackage : tses_pkg

//--- hw/tses_regfile.sv
// General register bank with three read ports and one write port
`timescale 1ns/10ps
module tses_regfile (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic we_i,
	input wire logic [3:0] waddr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] raddr_a_i,
	output logic [31:0] rdata_a_o,
	input wire logic [3:0] raddr_b_i,
	output logic [31:0] rdata_b_o,
	input wire logic [3:0] raddr_c_i,
	output logic [31:0] rdata_c_o
);
	logic [31:0] regs [16];

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < 16; i++)
			begin
				regs[i] <= (4'(i) == tses_pkg::SP_IDX) ? tses_pkg::SP_RESET : 32'h0000_0000;
			end
		end
		else if (we_i)
		begin
			regs[waddr_i] <= wdata_i;
		end
	end

	assign rdata_a_o = regs[raddr_a_i];
	assign rdata_b_o = regs[raddr_b_i];
	assign rdata_c_o = regs[raddr_c_i];
endmodule : tses_regfile
